// file: core/lls_cfg.svh
// Constants of the load latency sampler: field widths, reset values, source codes
`ifndef LLS_CFG_SVH
`define LLS_CFG_SVH

`define LLS_THR_W       16
`define LLS_THR_LSB     0
`define LLS_THR_RST     16'h0003
`define LLS_LAT_W       16
`define LLS_LAT_MAX     16'hffff
`define LLS_SRC_W       4
`define LLS_LFSR_W      16
`define LLS_LFSR_SEED   16'hace1
`define LLS_LFSR_TAPS   16'hb400
`define LLS_TAG_MASK    16'h000f
`define LLS_SRC_L3_UNK  4'h0
`define LLS_SRC_L1_HIT  4'h1
`define LLS_SRC_PEND    4'h2
`define LLS_SRC_L2_HIT  4'h3
`define LLS_SRC_L3_HIT  4'h4
`define LLS_SRC_SNP_CLN 4'h5
`define LLS_SRC_SNP_MOD 4'h6
`define LLS_SRC_LLC_MOD 4'h7
`define LLS_SRC_XPKG    4'h8
`define LLS_SRC_RSVD9   4'h9
`define LLS_SRC_LDRAM_S 4'ha
`define LLS_SRC_RDRAM_S 4'hb
`define LLS_SRC_LDRAM_E 4'hc
`define LLS_SRC_RDRAM_E 4'hd
`define LLS_SRC_IO      4'he
`define LLS_SRC_UC      4'hf

`endif

// file: core/lls_pkg.sv
// Types shared by the load latency sampler modules
package lls_pkg;
    typedef logic [15:0] lls_lat_t;
    typedef logic [3:0]  lls_src_t;
endpackage

// file: core/lls_mem_if.sv
// Carrier between the sampler core and its load address store
`timescale 1ns/10ps
interface lls_mem_if #(
    parameter int SLOT_W = 3,
    parameter int ADDR_W = 48
);
    logic              wr_en;
    logic [SLOT_W-1:0] wr_slot;
    logic [ADDR_W-1:0] wr_addr;
    logic [SLOT_W-1:0] rd_slot;
    logic [ADDR_W-1:0] rd_data;

    modport core (output wr_en, output wr_slot, output wr_addr, output rd_slot,
                  input rd_data);
    modport mem  (input wr_en, input wr_slot, input wr_addr, input rd_slot,
                  output rd_data);
endinterface

// file: core/lls_addr_mem.sv
// Per-slot linear address store with registered read data
`timescale 1ns/10ps
module lls_addr_mem #(
    parameter int SLOT_W = 3,
    parameter int ADDR_W = 48
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Core side
    lls_mem_if.mem    bus
);
    logic [ADDR_W-1:0] mem_q [2**SLOT_W];

    // Storage is not reset; only slots written at dispatch are ever read back
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_slot] <= bus.wr_addr;
        end
    end

    // Read data registered, one cycle after the slot is presented
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.rd_data <= '0;
        end else begin
            bus.rd_data <= mem_q[bus.rd_slot];
        end
    end
endmodule

// file: core/lls_sampler.sv
// Load latency sampler: tagging, per-slot latency, threshold and sample record
`timescale 1ns/10ps
`include "lls_cfg.svh"

module lls_sampler
    import lls_pkg::*;
#(
    parameter int         SLOT_W       = 3,
    parameter int         ADDR_W       = 48,
    parameter int         AFTER_W      = 16,
    parameter bit         LLC_MOD_EN   = 1'b0,
    parameter logic [15:0] TAG_MASK    = `LLS_TAG_MASK
) (
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    // Enables from the counter configuration
    input  wire logic                 LAT_EN,
    input  wire logic [AFTER_W-1:0]   SAMPLE_AFTER_VALUE,
    // Threshold register port
    input  wire logic                 THR_WR_EN,
    input  wire logic [31:0]          THR_WR_DATA,
    output logic [31:0]               THR_RD_DATA,
    // Load dispatch
    input  wire logic                 DISP_VALID,
    input  wire logic                 DISP_IS_LOAD,
    input  wire logic [SLOT_W-1:0]    DISP_SLOT,
    input  wire logic [ADDR_W-1:0]    DISP_ADDR,
    // Global observation
    input  wire logic                 GO_VALID,
    input  wire logic [SLOT_W-1:0]    GO_SLOT,
    input  wire logic [3:0]           GO_SOURCE,
    // Retirement
    input  wire logic                 RET_VALID,
    input  wire logic [SLOT_W-1:0]    RET_SLOT,
    // Counter increment and sample record
    output logic                      COUNT_INC,
    output logic                      REC_VALID,
    output logic [ADDR_W-1:0]         REC_ADDR,
    output logic [15:0]               REC_LATENCY,
    output logic [3:0]                REC_SOURCE
);
    localparam int NSLOT = 2**SLOT_W;

    lls_mem_if #(.SLOT_W(SLOT_W), .ADDR_W(ADDR_W)) mem_bus ();

    lls_addr_mem #(.SLOT_W(SLOT_W), .ADDR_W(ADDR_W)) u_mem (
        .clk (CORE_CLK),
        .rst (RST),
        .bus (mem_bus.mem)
    );

    logic [`LLS_THR_W-1:0]  threshold;
    logic [`LLS_LFSR_W-1:0] lfsr;
    logic                   slot_ld  [NSLOT];
    logic                   slot_tag [NSLOT];
    logic                   slot_run [NSLOT];
    lls_lat_t               slot_lat [NSLOT];
    lls_src_t               slot_src [NSLOT];
    logic                   ret_q;
    logic                   ret_tag_q;
    lls_lat_t               ret_lat_q;
    lls_src_t               ret_src_q;
    logic [AFTER_W-1:0]     after_cnt;
    logic [ADDR_W-1:0]      last_addr;
    lls_lat_t               last_lat;
    lls_src_t               last_src;

    // Decode of incoming events
    wire logic        disp_load = DISP_VALID & DISP_IS_LOAD & LAT_EN;
    wire logic        pick      = (lfsr & TAG_MASK) == '0;
    wire logic [`LLS_LFSR_W-1:0] next_lfsr =
        lfsr[0] ? ((lfsr >> 1) ^ `LLS_LFSR_TAPS) : (lfsr >> 1);
    wire logic        above     = ret_q & (ret_lat_q > threshold);
    wire logic        sampled   = above & ret_tag_q;
    wire logic        assist    = sampled & (after_cnt == '0);

    // Source code clean-up: reserved values never leave the block
    function automatic lls_src_t clean_src(input lls_src_t s);
        lls_src_t r;
        r = s;
        if (s == `LLS_SRC_RSVD9) begin
            r = `LLS_SRC_L3_UNK;
        end else if (s == `LLS_SRC_LLC_MOD && !LLC_MOD_EN) begin
            r = `LLS_SRC_SNP_MOD;
        end
        return r;
    endfunction

    // Memory port steering
    assign mem_bus.wr_en   = disp_load;
    assign mem_bus.wr_slot = DISP_SLOT;
    assign mem_bus.wr_addr = DISP_ADDR;
    assign mem_bus.rd_slot = RET_SLOT;

    // Threshold register, upper bits read as zero
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            threshold <= `LLS_THR_RST;
        end else if (THR_WR_EN) begin
            threshold <= THR_WR_DATA[`LLS_THR_W-1:`LLS_THR_LSB];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            THR_RD_DATA <= {16'h0000, `LLS_THR_RST};
        end else begin
            THR_RD_DATA <= {16'h0000, (THR_WR_EN ? THR_WR_DATA[15:0] : threshold)};
        end
    end

    // Pseudo-random selector, runs freely so tagging is not phase-locked
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            lfsr <= `LLS_LFSR_SEED;
        end else begin
            lfsr <= next_lfsr;
        end
    end

    // Per-slot tag, run flag, latency count and data source
    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
        wire logic hit_i  = DISP_VALID & (DISP_SLOT == SLOT_W'(i));
        wire logic disp_i = disp_load & (DISP_SLOT == SLOT_W'(i));
        wire logic go_i   = GO_VALID & (GO_SLOT == SLOT_W'(i)) & slot_run[i];
        wire logic sat_i  = slot_lat[i] == `LLS_LAT_MAX;

        always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
                slot_ld[i]  <= 1'b0;
                slot_tag[i] <= 1'b0;
                slot_run[i] <= 1'b0;
                slot_lat[i] <= '0;
                slot_src[i] <= `LLS_SRC_L3_UNK;
            end else if (disp_i) begin
                // A new dispatch restarts the slot; a GO in the same cycle is stale
                slot_ld[i]  <= 1'b1;
                slot_tag[i] <= pick;
                slot_run[i] <= 1'b1;
                slot_lat[i] <= '0;
                slot_src[i] <= `LLS_SRC_L3_UNK;
            end else if (hit_i) begin
                // Store or unmeasured load: stale state of the slot must not retire
                slot_ld[i]  <= 1'b0;
                slot_tag[i] <= 1'b0;
                slot_run[i] <= 1'b0;
            end else if (slot_run[i]) begin
                if (!sat_i) begin
                    slot_lat[i] <= slot_lat[i] + 16'h0001;
                end
                if (go_i) begin
                    slot_run[i] <= 1'b0;
                    slot_src[i] <= clean_src(GO_SOURCE);
                end
            end
        end
    end

    // Retire stage: slot state sampled alongside the address read
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ret_q     <= 1'b0;
            ret_tag_q <= 1'b0;
            ret_lat_q <= '0;
            ret_src_q <= `LLS_SRC_L3_UNK;
        end else begin
            ret_q     <= RET_VALID & LAT_EN & slot_ld[RET_SLOT];
            ret_tag_q <= slot_tag[RET_SLOT];
            ret_lat_q <= slot_lat[RET_SLOT];
            ret_src_q <= slot_src[RET_SLOT];
        end
    end

    // Counter increment for every load above threshold
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            COUNT_INC <= 1'b0;
        end else begin
            COUNT_INC <= above;
        end
    end

    // Last tagged load, updated on each qualifying tagged retire
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            last_addr <= '0;
            last_lat  <= '0;
            last_src  <= `LLS_SRC_L3_UNK;
        end else if (sampled) begin
            last_addr <= mem_bus.rd_data;
            last_lat  <= ret_lat_q;
            last_src  <= ret_src_q;
        end
    end

    // Sample-after countdown over tagged loads above threshold, reloaded at each assist
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            after_cnt <= '0;
        end else if (assist) begin
            after_cnt <= SAMPLE_AFTER_VALUE;
        end else if (sampled) begin
            after_cnt <= after_cnt - AFTER_W'(1);
        end
    end

    // Record write; the retiring load is the newest, so it is taken directly
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            REC_VALID   <= 1'b0;
            REC_ADDR    <= '0;
            REC_LATENCY <= '0;
            REC_SOURCE  <= `LLS_SRC_L3_UNK;
        end else begin
            REC_VALID <= assist;
            if (assist) begin
                REC_ADDR    <= mem_bus.rd_data;
                REC_LATENCY <= ret_lat_q;
                REC_SOURCE  <= ret_src_q;
            end
        end
    end

    // last_* hold the most recent tagged load above threshold for inspection between assists
    wire logic unused_last = ^{last_addr, last_lat, last_src};
endmodule

// file: dv/lls_props.sv
// Port checker for the load latency sampler
`timescale 1ns/10ps
module lls_props #(
    parameter bit LLC_MOD_EN = 1'b0
) (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // Watched ports
    input wire logic        LAT_EN,
    input wire logic        THR_WR_EN,
    input wire logic [31:0] THR_WR_DATA,
    input wire logic [31:0] THR_RD_DATA,
    input wire logic        RET_VALID,
    input wire logic        COUNT_INC,
    input wire logic        REC_VALID,
    input wire logic [15:0] REC_LATENCY,
    input wire logic [3:0]  REC_SOURCE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Threshold field and readback
    chk_thr_readback: assert property (THR_WR_EN |=>
        THR_RD_DATA == {16'h0000, $past(THR_WR_DATA[15:0])}) else $error("readback wrong");
    chk_thr_upper: assert property (THR_RD_DATA[31:16] == 16'h0000)
        else $error("upper bits set");
    // Source codes never reported
    chk_no_nine: assert property (REC_VALID |-> REC_SOURCE != 4'h9)
        else $error("code 9 seen");
    chk_no_seven: assert property (REC_VALID && !LLC_MOD_EN |-> REC_SOURCE != 4'h7)
        else $error("code 7 seen");
    // Outputs tied to the retire that caused them
    chk_rec_retire: assert property (REC_VALID |-> $past(RET_VALID, 2))
        else $error("record without retire");
    chk_cnt_retire: assert property (COUNT_INC |-> $past(RET_VALID, 2) && $past(LAT_EN, 2))
        else $error("count without retire");
    // Only loads above threshold are reported
    chk_rec_counted: assert property (REC_VALID |-> COUNT_INC)
        else $error("record not counted");
    chk_rec_above: assert property (REC_VALID |-> REC_LATENCY > THR_RD_DATA[15:0])
        else $error("latency not above threshold");
    // Record fields hold between records
    chk_rec_hold: assert property (!REC_VALID |->
        $stable(REC_LATENCY) && $stable(REC_SOURCE)) else $error("record changed");
    cov_rec: cover property (REC_VALID);
    cov_cnt_only: cover property (COUNT_INC && !REC_VALID);
    cov_thr: cover property (THR_WR_EN);
endmodule
bind lls_sampler lls_props #(.LLC_MOD_EN(LLC_MOD_EN)) u_lls_props (
    .CORE_CLK(CORE_CLK), .RST(RST), .LAT_EN(LAT_EN), .THR_WR_EN(THR_WR_EN),
    .THR_WR_DATA(THR_WR_DATA), .THR_RD_DATA(THR_RD_DATA), .RET_VALID(RET_VALID),
    .COUNT_INC(COUNT_INC), .REC_VALID(REC_VALID), .REC_LATENCY(REC_LATENCY),
    .REC_SOURCE(REC_SOURCE));

// file: dv/lls_pipe_model.sv
// Load pipeline model: dispatches, observes and retires one load at a time
`timescale 1ns/10ps
module lls_pipe_model (
    // Clock
    input wire logic    clk,
    // Dispatch
    output logic        disp_valid,
    output logic        disp_is_load,
    output logic [2:0]  disp_slot,
    output logic [47:0] disp_addr,
    // Global observation
    output logic        go_valid,
    output logic [2:0]  go_slot,
    output logic [3:0]  go_source,
    // Retirement
    output logic        ret_valid,
    output logic [2:0]  ret_slot
);
    // Idle at time zero
    initial begin
        {disp_valid, disp_is_load, go_valid, ret_valid} = 4'h0;
        {disp_slot, go_slot, ret_slot} = 9'h000;
        disp_addr = 48'h0;
        go_source = 4'h0;
    end
    // GO lands lat cycles after dispatch, retire one cycle later
    task automatic run_load(input logic [2:0] s, input logic [47:0] a, input int lat,
                            input logic [3:0] src, input logic is_ld);
        @(posedge clk) #1;
        {disp_valid, disp_is_load, disp_slot, disp_addr} = {1'b1, is_ld, s, a};
        @(posedge clk) #1;
        disp_valid = 1'b0;
        disp_addr = ~a; // Released lines never echo the old value
        repeat (lat - 1) @(posedge clk);
        #1;
        {go_valid, go_slot, go_source} = {1'b1, s, src};
        @(posedge clk) #1;
        {go_valid, go_source, ret_valid, ret_slot} = {1'b0, ~src, 1'b1, s};
        @(posedge clk) #1;
        ret_valid = 1'b0;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the load latency sampler
`timescale 1ns/10ps
module testbench;
    logic clk, rst, lat_en, thr_we, dv, dl, gv, rv, cnt, rec_v;
    logic [15:0] skip_n, rec_l;
    logic [31:0] thr_wd, thr_rd;
    logic [2:0] ds, gs, rs;
    logic [47:0] da, rec_a;
    logic [3:0] gsrc, rec_s;
    logic [47:0] nxt_addr = 48'h1234_5678_9a00;
    int err_total = 0, checks = 0, n_cnt = 0, n_rec = 0;
    // Every load tagged so records are predictable
    lls_sampler #(.TAG_MASK(16'h0000)) u_lls_sampler (.CORE_CLK(clk), .RST(rst),
        .LAT_EN(lat_en), .SAMPLE_AFTER_VALUE(skip_n), .THR_WR_EN(thr_we), .THR_WR_DATA(thr_wd),
        .THR_RD_DATA(thr_rd), .DISP_VALID(dv), .DISP_IS_LOAD(dl), .DISP_SLOT(ds),
        .DISP_ADDR(da), .GO_VALID(gv), .GO_SLOT(gs), .GO_SOURCE(gsrc), .RET_VALID(rv),
        .RET_SLOT(rs), .COUNT_INC(cnt), .REC_VALID(rec_v), .REC_ADDR(rec_a),
        .REC_LATENCY(rec_l), .REC_SOURCE(rec_s));
    lls_pipe_model u_lls_pipe_model (.clk(clk), .disp_valid(dv), .disp_is_load(dl),
        .disp_slot(ds), .disp_addr(da), .go_valid(gv), .go_slot(gs), .go_source(gsrc),
        .ret_valid(rv), .ret_slot(rs));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // One-cycle pulses tallied where they stand
    always @(posedge clk) begin
        if (cnt === 1'b1) n_cnt++;
        if (rec_v === 1'b1) n_rec++;
    end
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_thr(input logic [31:0] v);
        @(posedge clk) #1;
        {thr_we, thr_wd} = {1'b1, v};
        @(posedge clk) #1;
        thr_we = 1'b0;
    endtask
    // One load, then pulse tallies compared
    task automatic ld(input int lat, input logic [3:0] src, input logic is_ld,
                      input int e_cnt, input int e_rec);
        int c0, r0;
        c0 = n_cnt;
        r0 = n_rec;
        nxt_addr = nxt_addr + 48'h40;
        u_lls_pipe_model.run_load(3'h1, nxt_addr, lat, src, is_ld);
        repeat (4) @(posedge clk);
        #1;
        check("count pulses", 48'(e_cnt), 48'(n_cnt - c0));
        check("records", 48'(e_rec), 48'(n_rec - r0));
    endtask
    task automatic t_reset();
        check("threshold", 48'h3, 48'(thr_rd));
        check("outputs", 48'h0, {46'h0, cnt, rec_v});
        $display("reset test done");
    endtask
    task automatic t_thr();
        wr_thr(32'hffff_0010);
        check("threshold", 48'h10, 48'(thr_rd));
        wr_thr(32'h0000_0003);
        $display("threshold test done");
    endtask
    // Every source code; 9 and 7 are not passed through
    task automatic t_codes();
        logic [3:0] e;
        for (int c = 0; c < 16; c++) begin
            e = (c == 9) ? 4'h0 : (c == 7) ? 4'h6 : 4'(c);
            ld(5, 4'(c), 1'b1, 1, 1);
            check("latency", 48'h5, 48'(rec_l));
            check("source", 48'(e), 48'(rec_s));
            check("address", nxt_addr, rec_a);
        end
        $display("code test done");
    endtask
    task automatic t_edge();
        wr_thr(32'h0000_0005);
        ld(5, 4'h3, 1'b1, 0, 0);
        ld(6, 4'h3, 1'b1, 1, 1);
        wr_thr(32'h0000_0003);
        $display("threshold edge test done");
    endtask
    task automatic t_refuse();
        ld(8, 4'h3, 1'b0, 0, 0);
        lat_en = 1'b0;
        ld(8, 4'h3, 1'b1, 0, 0);
        lat_en = 1'b1;
        $display("refusal test done");
    endtask
    task automatic t_sat();
        ld(65600, 4'h1, 1'b1, 1, 1);
        check("saturated latency", 48'hffff, 48'(rec_l));
        $display("saturation test done");
    endtask
    // Two qualifying loads skipped between records
    task automatic t_skip();
        skip_n = 16'h0002;
        for (int i = 0; i < 4; i++) ld(6, 4'h3, 1'b1, 1, int'(i == 0 || i == 3));
        $display("sample-after test done");
    endtask
    initial begin
        {rst, lat_en, thr_we} = 3'b100;
        skip_n = 16'h0000;
        thr_wd = 32'h0;
        repeat (16) @(posedge clk);
        #1;
        {rst, lat_en} = 2'b01;
        t_reset();
        t_thr();
        t_codes();
        t_edge();
        t_refuse();
        t_sat();
        t_skip();
        complete_run();
    end
    // Hang guard well past the longest load
    initial begin
        repeat (75000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule
